// file: hdl/isf_consts.svh
// offsets, field positions, reset values and codes for the status-flag block
`ifndef ISF_CONSTS_SVH
`define ISF_CONSTS_SVH
`define ISF_OFF_STATUS   12'h008
`define ISF_OFF_MASK     12'h004
`define ISF_OFF_CTRL     12'h024
`define ISF_OFF_VECTOR   12'h028
`define ISF_OFF_TXDATA   12'h020
`define ISF_OFF_RXDATA   12'h018
`define ISF_OFF_OWNADDR  12'h000
`define ISF_BIT_SLVA     9
`define ISF_BIT_GC       8
`define ISF_BIT_STOP     5
`define ISF_BIT_TXR      4
`define ISF_BIT_RXR      3
`define ISF_FLAG_MASK    32'h0000_0338
`define ISF_CTRL_RST     32'h0000_0000
`define ISF_CTRL_RELEASE 5
`define ISF_CTRL_FREEFMT 3
`define ISF_CODE_NONE    3'h0
`define ISF_CODE_RXR     3'h4
`define ISF_CODE_TXR     3'h5
`define ISF_CODE_STOP    3'h6
`define ISF_CODE_SLVA    3'h7
`endif

// file: hdl/isf_pkg.sv
// types shared by the status-flag block
package isf_pkg;
    typedef struct packed {
        logic       addr_match;
        logic       gen_call;
        logic       first_word;
        logic       start_seen;
        logic       rstart_seen;
        logic       stop_seen;
        logic       tx_load;
        logic       rx_load;
        logic [7:0] rx_byte;
    } isf_eng_s;
    typedef struct packed {
        logic       slave_addressed;
        logic       general_call;
        logic       stop_detected;
        logic       tx_ready;
        logic       rx_ready;
    } isf_flags_s;
    typedef enum logic [1:0] {ISF_IDLE, ISF_DATA} isf_phase_e;
endpackage

// file: hdl/isf_flag.sv
// one sticky flag: set wins over clear, reset forces a chosen level
`timescale 1ns/1ps
module isf_flag #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic mod_rst,
    input  wire logic set_ev,
    input  wire logic clr_ev,
    output logic      flag_ff
);
    always_ff @(posedge core_clk) begin
        if (!reset_n || mod_rst) begin
            flag_ff <= RST_VAL;
        end else if (set_ev) begin
            flag_ff <= 1'b1;
        end else if (clr_ev) begin
            flag_ff <= 1'b0;
        end
    end
endmodule // isf_flag

// file: hdl/isf_status.sv
// status-flag logic of the i2c controller with ahb-lite register slave
`timescale 1ns/1ps
`include "isf_consts.svh"
module isf_status
    import isf_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire isf_eng_s    eng,
    output logic             tx_data_valid,
    output logic      [7:0]  tx_byte,
    output logic      [6:0]  own_address,
    output logic             free_format,
    output logic             module_in_reset,
    output logic             tx_ready_request,
    output logic             rx_ready_request,
    output logic             irq
);
    logic [31:0] ctrl_ff;
    logic [31:0] mask_ff;
    logic [6:0]  own_addr_ff;
    logic [7:0]  tx_data_ff;
    logic [7:0]  rx_data_ff;
    logic        txv_ff;
    logic        ph_wr_ff;
    logic        ph_rd_ff;
    logic [11:0] ph_addr_ff;
    logic [31:0] hrdata_ff;
    logic        irq_ff;
    logic        txreq_ff;
    logic        rxreq_ff;
    logic        mrst_ff;
    isf_phase_e  phase_ff;
    isf_flags_s  fl;
    logic        mod_rst;
    logic        addr_ok;
    logic [31:0] status_word;
    logic [2:0]  nxt_code;
    logic [31:0] nxt_rdata;
    logic        w1c;
    logic        vec_rd;
    logic        rx_rd;
    logic        tx_wr;
    logic        slva_set;

    // release bit low holds the engine side except the stop flag in reset
    assign mod_rst = !ctrl_ff[`ISF_CTRL_RELEASE];

    // single-cycle data phase: zero wait states, always okay
    assign addr_ok = hsel && hready && htrans[1];
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ph_wr_ff   <= 1'b0;
            ph_rd_ff   <= 1'b0;
            ph_addr_ff <= 12'h000;
            phase_ff   <= ISF_IDLE;
        end else begin
            ph_wr_ff   <= addr_ok && hwrite;
            ph_rd_ff   <= addr_ok && !hwrite;
            ph_addr_ff <= haddr;
            phase_ff   <= addr_ok ? ISF_DATA : ISF_IDLE;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read side effects happen at the address phase so data is ready
    assign vec_rd = addr_ok && !hwrite && haddr == `ISF_OFF_VECTOR;
    assign rx_rd  = addr_ok && !hwrite && haddr == `ISF_OFF_RXDATA;
    assign w1c    = ph_wr_ff && ph_addr_ff == `ISF_OFF_STATUS;
    assign tx_wr  = ph_wr_ff && ph_addr_ff == `ISF_OFF_TXDATA;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_ff     <= `ISF_CTRL_RST;
            mask_ff     <= 32'h0000_0000;
            own_addr_ff <= 7'h00;
            tx_data_ff  <= 8'h00;
        end else if (ph_wr_ff) begin
            case (ph_addr_ff)
                `ISF_OFF_CTRL:    ctrl_ff <= hwdata;
                `ISF_OFF_MASK:    mask_ff <= hwdata & `ISF_FLAG_MASK;
                `ISF_OFF_OWNADDR: own_addr_ff <= hwdata[6:0];
                `ISF_OFF_TXDATA:  tx_data_ff <= hwdata[7:0];
                default:          ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n || mod_rst) begin
            txv_ff     <= 1'b0;
            rx_data_ff <= 8'h00;
        end else begin
            if (tx_wr) begin
                txv_ff <= 1'b1;
            end else if (eng.tx_load) begin
                txv_ff <= 1'b0;
            end
            if (eng.rx_load) begin
                rx_data_ff <= eng.rx_byte;
            end
        end
    end

    assign slva_set = eng.addr_match || eng.gen_call
                  || (ctrl_ff[`ISF_CTRL_FREEFMT] && eng.first_word);

    isf_flag #(.RST_VAL(1'b0)) u_slva (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .mod_rst  (mod_rst),
        .set_ev   (slva_set),
        .clr_ev   (eng.rstart_seen || eng.stop_seen),
        .flag_ff  (fl.slave_addressed)
    );
    isf_flag #(.RST_VAL(1'b0)) u_gc (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .mod_rst  (mod_rst),
        .set_ev   (eng.gen_call),
        .clr_ev   (eng.start_seen || eng.stop_seen),
        .flag_ff  (fl.general_call)
    );
    isf_flag #(.RST_VAL(1'b0)) u_stop (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .mod_rst  (1'b0),
        .set_ev   (eng.stop_seen),
        .clr_ev   ((vec_rd && nxt_code == `ISF_CODE_STOP)
                   || (w1c && hwdata[`ISF_BIT_STOP])),
        .flag_ff  (fl.stop_detected)
    );
    isf_flag #(.RST_VAL(1'b1)) u_txr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .mod_rst  (mod_rst),
        .set_ev   (eng.tx_load),
        .clr_ev   (tx_wr || (w1c && hwdata[`ISF_BIT_TXR])),
        .flag_ff  (fl.tx_ready)
    );
    isf_flag #(.RST_VAL(1'b0)) u_rxr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .mod_rst  (mod_rst),
        .set_ev   (eng.rx_load),
        .clr_ev   (rx_rd || (w1c && hwdata[`ISF_BIT_RXR])),
        .flag_ff  (fl.rx_ready)
    );

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`ISF_BIT_SLVA] = fl.slave_addressed;
        status_word[`ISF_BIT_GC]   = fl.general_call;
        status_word[`ISF_BIT_STOP] = fl.stop_detected;
        status_word[`ISF_BIT_TXR] = fl.tx_ready;
        status_word[`ISF_BIT_RXR] = fl.rx_ready;
    end

    // highest unmasked pending source, stop ranked over data flags
    always_comb begin
        logic [31:0] pend;
        pend = status_word & mask_ff;
        if (pend[`ISF_BIT_SLVA]) begin
            nxt_code = `ISF_CODE_SLVA;
        end else if (pend[`ISF_BIT_STOP]) begin
            nxt_code = `ISF_CODE_STOP;
        end else if (pend[`ISF_BIT_TXR]) begin
            nxt_code = `ISF_CODE_TXR;
        end else if (pend[`ISF_BIT_RXR]) begin
            nxt_code = `ISF_CODE_RXR;
        end else begin
            nxt_code = `ISF_CODE_NONE;
        end
    end

    always_comb begin
        case (haddr)
            `ISF_OFF_STATUS:  nxt_rdata = status_word;
            `ISF_OFF_MASK:    nxt_rdata = mask_ff;
            `ISF_OFF_CTRL:    nxt_rdata = ctrl_ff;
            `ISF_OFF_VECTOR:  nxt_rdata = {29'h0, nxt_code};
            `ISF_OFF_RXDATA:  nxt_rdata = {24'h0, rx_data_ff};
            `ISF_OFF_TXDATA:  nxt_rdata = {24'h0, tx_data_ff};
            `ISF_OFF_OWNADDR: nxt_rdata = {25'h0, own_addr_ff};
            default:          nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_ff <= nxt_rdata;
        end
    end
    assign hrdata = hrdata_ff;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_ff   <= 1'b0;
            txreq_ff <= 1'b0;
            rxreq_ff <= 1'b0;
            mrst_ff  <= 1'b1;
        end else begin
            irq_ff   <= |(status_word & mask_ff);
            txreq_ff <= fl.tx_ready;
            rxreq_ff <= fl.rx_ready;
            mrst_ff  <= mod_rst;
        end
    end
    assign irq              = irq_ff;
    assign tx_ready_request = txreq_ff;
    assign rx_ready_request = rxreq_ff;
    assign module_in_reset  = mrst_ff;
    assign tx_data_valid    = txv_ff;
    assign tx_byte          = tx_data_ff;
    assign own_address      = own_addr_ff;
    assign free_format      = ctrl_ff[`ISF_CTRL_FREEFMT];

    sequence s_stop_ev;
        eng.stop_seen;
    endsequence
    sequence s_stop_high;
        fl.stop_detected;
    endsequence

    AST_SLVA_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.addr_match && !mod_rst) |=> fl.slave_addressed)
        else $error("slave-addressed not set on match");
    AST_FREE_FMT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.first_word && ctrl_ff[`ISF_CTRL_FREEFMT] && !mod_rst)
        |=> fl.slave_addressed)
        else $error("free format first word missed");
    AST_SLVA_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.stop_seen && !slva_set) |=> !fl.slave_addressed)
        else $error("slave-addressed not cleared by stop");
    AST_GC_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.start_seen && !eng.gen_call) |=> !fl.general_call)
        else $error("general call not cleared by start");
    AST_RSVD: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ph_rd_ff && ph_addr_ff == `ISF_OFF_STATUS) |-> hrdata[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    AST_STOP_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_stop_ev |=> s_stop_high ##1 $past(fl.stop_detected))
        else $error("stop not recorded");
    AST_TXR_RST: assert property (@(posedge core_clk) disable iff (!reset_n)
        mod_rst |=> fl.tx_ready)
        else $error("tx ready not forced in reset");
    AST_TXR_WR: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tx_wr && !eng.tx_load && !mod_rst) |=> !fl.tx_ready)
        else $error("tx ready kept after data write");
    AST_RXR_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.rx_load && !mod_rst) |=> fl.rx_ready ##1 rxreq_ff)
        else $error("rx ready or request missing");
    AST_RXR_RD: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rx_rd && !eng.rx_load) |=> !fl.rx_ready)
        else $error("rx ready kept after data read");
    AST_SLVA_RSTART: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.rstart_seen && !slva_set)
        |=> !fl.slave_addressed)
        else $error("slave-addressed not cleared by repeated start");
    AST_GC_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.gen_call && !mod_rst)
        |=> fl.general_call)
        else $error("general call not set");
    AST_GC_STOP: assert property (@(posedge core_clk) disable iff (!reset_n)
        (eng.stop_seen && !eng.gen_call)
        |=> !fl.general_call)
        else $error("general call not cleared by stop");
    AST_STOP_VEC: assert property (@(posedge core_clk) disable iff (!reset_n)
        (vec_rd && nxt_code == `ISF_CODE_STOP && !eng.stop_seen)
        |=> !fl.stop_detected)
        else $error("stop flag kept after vector read");
    AST_STOP_W1C: assert property (@(posedge core_clk) disable iff (!reset_n)
        (w1c && hwdata[`ISF_BIT_STOP] && !eng.stop_seen)
        |=> !fl.stop_detected)
        else $error("stop flag kept after write one");
    AST_STOP_KEEP: assert property (@(posedge core_clk) disable iff (!reset_n)
        (w1c && !hwdata[`ISF_BIT_STOP] && !vec_rd && fl.stop_detected)
        |=> fl.stop_detected)
        else $error("stop flag lost on zero write");
    AST_TXR_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        eng.tx_load
        |=> fl.tx_ready)
        else $error("tx ready not set on shift load");
    AST_TXR_W1C: assert property (@(posedge core_clk) disable iff (!reset_n)
        (w1c && hwdata[`ISF_BIT_TXR] && !eng.tx_load && !mod_rst)
        |=> !fl.tx_ready)
        else $error("tx ready kept after write one");
    AST_TXREQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        fl.tx_ready
        |=> txreq_ff)
        else $error("tx request does not follow flag");
    AST_RXREQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        fl.rx_ready
        |=> rxreq_ff)
        else $error("rx request does not follow flag");
    AST_RXR_W1C: assert property (@(posedge core_clk) disable iff (!reset_n)
        (w1c && hwdata[`ISF_BIT_RXR] && !eng.rx_load)
        |=> !fl.rx_ready)
        else $error("rx ready kept after write one");
    AST_RXR_MRST: assert property (@(posedge core_clk) disable iff (!reset_n)
        mod_rst
        |=> !fl.rx_ready)
        else $error("rx ready set during module reset");
    AST_MRST_OUT: assert property (@(posedge core_clk) disable iff (!reset_n)
        mod_rst
        |=> module_in_reset)
        else $error("module reset not reported");
endmodule // isf_status

// file: verif/isf_eng_model.sv
// protocol engine stand-in: forwards bus events, loads transmit data
`timescale 1ns/1ps
module isf_eng_model
    import isf_pkg::*;
(
    input  wire logic     core_clk,
    input  wire logic     reset_n,
    input  wire logic     slow,
    input  wire logic     tx_data_valid,
    input  wire isf_eng_s ev,
    output isf_eng_s      eng
);
    logic [3:0] wait_ff;
    logic       ld_ff;
    // shift register takes the byte only after a chosen delay
    always_ff @(posedge core_clk) begin
        if (!reset_n || !tx_data_valid || ld_ff) begin
            wait_ff <= slow ? 4'hC : 4'h1;
            ld_ff   <= 1'b0;
        end else if (wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else begin
            ld_ff <= 1'b1;
        end
    end
    always_comb begin
        eng         = ev;
        eng.tx_load = ld_ff;
    end
endmodule // isf_eng_model

// file: verif/isf_status_tb.sv
// self-checking bench for the status-flag block
`timescale 1ns/1ps
`include "isf_consts.svh"
module isf_status_tb
    import isf_pkg::*;
;
    localparam logic [15:0] ev_am = 16'h8000, ev_gc = 16'h4000;
    localparam logic [15:0] ev_fw = 16'h2000, ev_st = 16'h1000;
    localparam logic [15:0] ev_rs = 16'h0800, ev_sp = 16'h0400;
    localparam logic [15:0] ev_rx = 16'h0100;
    logic        core_clk, reset_n, hsel, hwrite, hready, hresp, slow;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd, rnd;
    isf_eng_s    ev, eng;
    logic        tx_data_valid, free_format, module_in_reset;
    logic        txq, rxq, irq;
    logic [7:0]  tx_byte;
    logic [6:0]  own_address;
    int          err_count, checks_done;

    isf_status i_isf_status (.core_clk(core_clk), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .eng(eng),
        .tx_data_valid(tx_data_valid), .tx_byte(tx_byte),
        .own_address(own_address), .free_format(free_format),
        .module_in_reset(module_in_reset), .tx_ready_request(txq),
        .rx_ready_request(rxq), .irq(irq));
    isf_eng_model i_isf_eng_model (.core_clk(core_clk), .reset_n(reset_n),
        .slow(slow), .tx_data_valid(tx_data_valid), .ev(ev), .eng(eng));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // one ahb-lite single transfer; read data lands in rd
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic st(input logic [31:0] e);
        bus(1'b0, `ISF_OFF_STATUS, 32'h0);
        chk(rd, e);
    endtask
    task automatic pulse(input logic [15:0] p);
        ev <= p;
        @(posedge core_clk);
        ev <= '0;
    endtask
    task automatic done_t(input string n);
        $display("test %s done", n);
    endtask
    task automatic tx_round(input logic s);
        slow <= s;
        rnd = lfsr(rnd);
        bus(1'b1, `ISF_OFF_TXDATA, rnd);
        @(posedge core_clk);
        chkb(tx_data_valid, 1'b1);
        chk({24'h0, tx_byte}, {24'h0, rnd[7:0]});
        if (s) st(32'h0);
        for (int i = 0; i < 30 && txq !== 1'b1; i++) @(posedge core_clk);
        chkb(txq, 1'b1);
        st(32'h10);
        bus(1'b1, `ISF_OFF_STATUS, 32'h10);
        st(32'h0);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        stop_test();
    end
    initial begin
        {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        ev = '0;
        slow = 1'b1;
        err_count = 0;
        checks_done = 0;
        rnd = 32'h0001_69E7;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        chkb(module_in_reset, 1'b1);
        st(32'h10);
        bus(1'b1, `ISF_OFF_CTRL, 32'h20);
        repeat (2) @(posedge core_clk);
        chkb(module_in_reset, 1'b0);
        done_t("reset");
        tx_round(1'b1);
        tx_round(1'b0);
        done_t("transmit");
        pulse(ev_am);
        st(32'h200);
        pulse(ev_rs);
        st(32'h0);
        pulse(ev_gc);
        st(32'h300);
        pulse(ev_st);
        st(32'h200);
        pulse(ev_sp);
        st(32'h20);
        rnd = lfsr(rnd);
        bus(1'b1, `ISF_OFF_STATUS, rnd & 32'hFFFF_FFC7);
        st(32'h20);
        bus(1'b1, `ISF_OFF_MASK, 32'h20);
        repeat (2) @(posedge core_clk);
        chkb(irq, 1'b1);
        bus(1'b0, `ISF_OFF_VECTOR, 32'h0);
        chk({29'h0, rd[2:0]}, 32'h6);
        st(32'h0);
        chkb(irq, 1'b0);
        pulse(ev_sp);
        bus(1'b1, `ISF_OFF_STATUS, 32'h20);
        st(32'h0);
        bus(1'b1, `ISF_OFF_CTRL, 32'h28);
        pulse(ev_fw);
        chkb(free_format, 1'b1);
        st(32'h200);
        pulse(ev_rs);
        st(32'h0);
        bus(1'b1, `ISF_OFF_CTRL, 32'h20);
        done_t("address");
        rnd = lfsr(rnd);
        pulse(ev_rx | {8'h0, rnd[7:0]});
        st(32'h8);
        chkb(rxq, 1'b1);
        bus(1'b1, `ISF_OFF_MASK, 32'h8);
        repeat (2) @(posedge core_clk);
        chkb(irq, 1'b1);
        bus(1'b0, `ISF_OFF_RXDATA, 32'h0);
        chk(rd, {24'h0, rnd[7:0]});
        st(32'h0);
        pulse(ev_rx);
        bus(1'b1, `ISF_OFF_STATUS, 32'h8);
        st(32'h0);
        done_t("receive");
        bus(1'b1, `ISF_OFF_STATUS, 32'hC0);
        st(32'h0);
        bus(1'b0, 12'h100, 32'h0);
        chk(rd, 32'h0);
        chkb(hresp, 1'b0);
        bus(1'b1, `ISF_OFF_OWNADDR, rnd);
        @(posedge core_clk);
        chk({25'h0, own_address}, {25'h0, rnd[6:0]});
        pulse(ev_rx);
        bus(1'b1, `ISF_OFF_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        chkb(module_in_reset, 1'b1);
        st(32'h10);
        done_t("misc");
        stop_test();
    end
endmodule // isf_status_tb
